// *** src/pin_state_defs.svh ***
// Constants for the pin state controller
`ifndef PIN_STATE_DEFS_SVH
`define PIN_STATE_DEFS_SVH
`define OFS_CTRL 12'h000
`define OFS_P6_DIR 12'h004
`define OFS_P6_OUT 12'h008
`define OFS_P8_DIR 12'h00C
`define OFS_P8_OUT 12'h010
`define OFS_PA_DIR 12'h014
`define OFS_PA_OUT 12'h018
`define OFS_PA_TOE 12'h01C
`define OFS_STATUS 12'h020
`define OFS_PIN_IN 12'h024
`define CTRL_BUS_RELEASE_ENABLE_BIT_BIT 0
`define CTRL_SSBY_BIT 1
`define P6_REQ_BIT 1
`define P6_GNT_BIT 2
`define P8_IN_BIT 1
`define PA_HIGH_LSB 4
`define PA_HIGH_WIDTH 4
`define MODE_WIDE_A 3'h3
`define MODE_WIDE_B 3'h4
`define RESET_BYTE 8'h00
`endif

// *** src/pin_state_pkg.sv ***
// Types shared by the pin state controller
package pin_state_pkg;
  typedef enum logic [2:0] {
    PWR_RUN = 3'b000,
    PWR_SLEEP = 3'b001,
    PWR_SW_STBY = 3'b010,
    PWR_HW_STBY = 3'b011,
    PWR_BUS_REL = 3'b100
  } power_state_type;
endpackage

// *** src/pin_cell.sv ***
// One port pin cell: drive, float or hold
`timescale 1ns/1ps
`default_nettype none
module pin_cell (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic hold,
  input wire logic force_float,
  input wire logic func_en,
  input wire logic func_out,
  input wire logic func_oe,
  input wire logic port_dir,
  input wire logic port_out,
  output logic pin_o,
  output logic pin_oe
);
  logic lvl_q, lvl_d, oe_q, oe_d;

  // Live selection, or frozen copy while held
  always_comb begin
    lvl_d = lvl_q;
    oe_d = oe_q;
    if (force_float) begin
      oe_d = 1'b0;
    end else if (!hold) begin
      lvl_d = func_en ? func_out : port_out;
      oe_d = func_en ? func_oe : port_dir;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lvl_q <= 1'b0;
      oe_q <= 1'b0;
    end else begin
      lvl_q <= lvl_d;
      oe_q <= oe_d;
    end
  end

  assign pin_o = lvl_q;
  assign pin_oe = oe_q;
endmodule
`default_nettype wire

// *** src/pin_state_by_power_mode.sv ***
// Pin state controller across power states
// How it works
// - Held pins: inputs float, outputs keep level
// - Standby request pin: keep, or float if enabled
// - Standby grant pin: keep, or high if enabled
// - Running request pin: port, or bus request input
// - Running grant pin: port, or grant output
// - Modes 3,4 standby: upper A follows direction
// - Modes 3,4 release: upper A uses timer enables
//
// The implementer's own choices: the APB slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "pin_state_defs.svh"
module pin_state_by_power_mode
  import pin_state_pkg::*;
#(
  parameter int NPINS = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [2:0] op_mode,
  input wire logic hw_standby_n,
  input wire logic bus_released,
  input wire logic sleep_req,
  input wire logic wake_req,
  input wire logic [3:0] timer_out,
  input wire logic [3:0] timer_oe,
  input wire logic [NPINS-1:0] port6_pin_i,
  output logic [NPINS-1:0] port6_pin_o,
  output logic [NPINS-1:0] port6_pin_oe,
  input wire logic [NPINS-1:0] port8_pin_i,
  output logic [NPINS-1:0] port8_pin_o,
  output logic [NPINS-1:0] port8_pin_oe,
  input wire logic [NPINS-1:0] porta_pin_i,
  output logic [NPINS-1:0] porta_pin_o,
  output logic [NPINS-1:0] porta_pin_oe,
  output logic bus_request_input,
  output logic [2:0] power_state
);
  logic [7:0] ctrl_q, ctrl_d, p6_dir_q, p6_dir_d, p6_out_q, p6_out_d;
  logic [7:0] p8_dir_q, p8_dir_d, p8_out_q, p8_out_d;
  logic [7:0] pa_dir_q, pa_dir_d, pa_out_q, pa_out_d, pa_toe_q, pa_toe_d;
  logic [2:0] mode_s1_q, mode_s2_q;
  logic [2:0] ctl_s1_q, ctl_s2_q;
  logic [NPINS-1:0] p6_s1_q, p6_s2_q, p8_s1_q, p8_s2_q, pa_s1_q, pa_s2_q;
  power_state_type st_q, st_d;
  logic bus_release_enable_bit, hw_sb, rel, sw_sb, wide_mode, held, wr_en;

  // Pin and strap synchronisers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_s1_q <= 3'h0;
      mode_s2_q <= 3'h0;
      ctl_s1_q <= 3'h0;
      ctl_s2_q <= 3'h0;
      p6_s1_q <= '0;
      p6_s2_q <= '0;
      p8_s1_q <= '0;
      p8_s2_q <= '0;
      pa_s1_q <= '0;
      pa_s2_q <= '0;
    end else begin
      mode_s1_q <= op_mode;
      mode_s2_q <= mode_s1_q;
      ctl_s1_q <= {~hw_standby_n, bus_released, wake_req};
      ctl_s2_q <= ctl_s1_q;
      p6_s1_q <= port6_pin_i;
      p6_s2_q <= p6_s1_q;
      p8_s1_q <= port8_pin_i;
      p8_s2_q <= p8_s1_q;
      pa_s1_q <= porta_pin_i;
      pa_s2_q <= pa_s1_q;
    end
  end

  assign bus_release_enable_bit = ctrl_q[`CTRL_BUS_RELEASE_ENABLE_BIT_BIT];
  assign hw_sb = ctl_s2_q[2];
  assign wide_mode = (mode_s2_q == `MODE_WIDE_A) || (mode_s2_q == `MODE_WIDE_B);
  assign wr_en = psel && penable && pwrite;

  // Power state sequencing
  always_comb begin
    st_d = st_q;
    if (hw_sb) begin
      st_d = PWR_HW_STBY;
    end else begin
      unique case (st_q)
        PWR_RUN: begin
          if (ctl_s2_q[1] && bus_release_enable_bit) st_d = PWR_BUS_REL;
          else if (sleep_req) st_d = ctrl_q[`CTRL_SSBY_BIT] ? PWR_SW_STBY : PWR_SLEEP;
        end
        PWR_SLEEP: begin
          if (ctl_s2_q[0]) st_d = PWR_RUN;
          else if (ctl_s2_q[1] && bus_release_enable_bit) st_d = PWR_BUS_REL;
        end
        PWR_SW_STBY: if (ctl_s2_q[0]) st_d = PWR_RUN;
        PWR_HW_STBY: st_d = PWR_RUN;
        PWR_BUS_REL: if (!ctl_s2_q[1]) st_d = PWR_RUN;
        default: st_d = PWR_RUN;
      endcase
    end
  end

  assign sw_sb = (st_q == PWR_SW_STBY);
  assign rel = (st_q == PWR_BUS_REL);
  assign held = sw_sb || rel;

  // Register writes
  always_comb begin
    ctrl_d = ctrl_q;
    p6_dir_d = p6_dir_q;
    p6_out_d = p6_out_q;
    p8_dir_d = p8_dir_q;
    p8_out_d = p8_out_q;
    pa_dir_d = pa_dir_q;
    pa_out_d = pa_out_q;
    pa_toe_d = pa_toe_q;
    if (wr_en) begin
      unique case (paddr)
        `OFS_CTRL: ctrl_d = pwdata[7:0];
        `OFS_P6_DIR: p6_dir_d = pwdata[7:0];
        `OFS_P6_OUT: p6_out_d = pwdata[7:0];
        `OFS_P8_DIR: p8_dir_d = pwdata[7:0] & ~(8'h01 << `P8_IN_BIT);
        `OFS_P8_OUT: p8_out_d = pwdata[7:0];
        `OFS_PA_DIR: pa_dir_d = pwdata[7:0];
        `OFS_PA_OUT: pa_out_d = pwdata[7:0];
        `OFS_PA_TOE: pa_toe_d = pwdata[7:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= PWR_RUN;
      ctrl_q <= `RESET_BYTE;
      p6_dir_q <= `RESET_BYTE;
      p6_out_q <= `RESET_BYTE;
      p8_dir_q <= `RESET_BYTE;
      p8_out_q <= `RESET_BYTE;
      pa_dir_q <= `RESET_BYTE;
      pa_out_q <= `RESET_BYTE;
      pa_toe_q <= `RESET_BYTE;
    end else begin
      st_q <= st_d;
      ctrl_q <= ctrl_d;
      p6_dir_q <= p6_dir_d;
      p6_out_q <= p6_out_d;
      p8_dir_q <= p8_dir_d;
      p8_out_q <= p8_out_d;
      pa_dir_q <= pa_dir_d;
      pa_out_q <= pa_out_d;
      pa_toe_q <= pa_toe_d;
    end
  end

  // Read mux, zero-wait, unmapped reads zero
  always_comb begin
    prdata = 32'h0000_0000;
    pslverr = 1'b0;
    unique case (paddr)
      `OFS_CTRL: prdata = {24'h0, ctrl_q};
      `OFS_P6_DIR: prdata = {24'h0, p6_dir_q};
      `OFS_P6_OUT: prdata = {24'h0, p6_out_q};
      `OFS_P8_DIR: prdata = {24'h0, p8_dir_q};
      `OFS_P8_OUT: prdata = {24'h0, p8_out_q};
      `OFS_PA_DIR: prdata = {24'h0, pa_dir_q};
      `OFS_PA_OUT: prdata = {24'h0, pa_out_q};
      `OFS_PA_TOE: prdata = {24'h0, pa_toe_q};
      `OFS_STATUS: prdata = {27'h0, wide_mode, hw_sb, st_q};
      `OFS_PIN_IN: prdata = {8'h0, pa_s2_q, p8_s2_q, p6_s2_q};
      default: pslverr = psel && penable;
    endcase
  end
  assign pready = 1'b1;

  // Bus request pin is an input only when release enabled, and only once its driver is off
  assign bus_request_input = bus_release_enable_bit && !held && !hw_sb && !port6_pin_oe[`P6_REQ_BIT] &&
    p6_s2_q[`P6_REQ_BIT];
  assign power_state = st_q;

  genvar i;
  generate
    for (i = 0; i < NPINS; i++) begin : g_pins
      logic p6_fen, p6_fo, p6_foe, p6_ff, p6_hold;
      logic pa_fen, pa_fo, pa_foe, pa_hold;
      // Port 6: request and grant pins
      always_comb begin
        p6_fen = 1'b0;
        p6_fo = 1'b0;
        p6_foe = 1'b0;
        p6_hold = held;
        p6_ff = hw_sb;
        if (i == `P6_REQ_BIT && bus_release_enable_bit) begin
          p6_fen = 1'b1;
          p6_ff = hw_sb || sw_sb || rel;
        end
        if (i == `P6_GNT_BIT && bus_release_enable_bit) begin
          p6_fen = 1'b1;
          p6_fo = !rel && !sw_sb ? 1'b1 : !sw_sb ? 1'b0 : 1'b1;
          p6_foe = 1'b1;
          p6_hold = 1'b0;
        end
      end
      pin_cell u_p6 (.pclk(pclk), .presetn(presetn), .hold(p6_hold), .force_float(p6_ff),
        .func_en(p6_fen), .func_out(p6_fo), .func_oe(p6_foe), .port_dir(p6_dir_q[i]),
        .port_out(p6_out_q[i]), .pin_o(port6_pin_o[i]), .pin_oe(port6_pin_oe[i]));
      // Port 8: bit 1 floats in standby
      pin_cell u_p8 (.pclk(pclk), .presetn(presetn), .hold(held),
        .force_float(hw_sb || (i == `P8_IN_BIT && sw_sb)),
        .func_en(1'b0), .func_out(1'b0), .func_oe(1'b0), .port_dir(p8_dir_q[i]),
        .port_out(p8_out_q[i]), .pin_o(port8_pin_o[i]), .pin_oe(port8_pin_oe[i]));
      // Port A: upper pins follow mode
      always_comb begin
        pa_fen = 1'b0;
        pa_fo = 1'b0;
        pa_foe = 1'b0;
        pa_hold = held;
        if (i >= `PA_HIGH_LSB && i < `PA_HIGH_LSB + `PA_HIGH_WIDTH && wide_mode) begin
          pa_hold = 1'b0;
          // Timer owns the pin only where both enables are set, else the port
          if (rel && pa_toe_q[i] && timer_oe[2'(i - `PA_HIGH_LSB)]) begin
            pa_fen = 1'b1;
            pa_fo = timer_out[2'(i - `PA_HIGH_LSB)];
            pa_foe = 1'b1;
          end
        end
      end
      pin_cell u_pa (.pclk(pclk), .presetn(presetn), .hold(pa_hold), .force_float(hw_sb),
        .func_en(pa_fen), .func_out(pa_fo), .func_oe(pa_foe), .port_dir(pa_dir_q[i]),
        .port_out(pa_out_q[i]), .pin_o(porta_pin_o[i]), .pin_oe(porta_pin_oe[i]));
    end
  endgenerate
endmodule
`default_nettype wire

// *** sim/pin_state_checker.sv ***
// Assertions on pin states across power states
`timescale 1ns/1ps
`default_nettype none
module pin_state_checker #(parameter int NPINS = 8) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [2:0] power_state,
  input wire logic [2:0] op_mode,
  input wire logic [3:0] timer_out,
  input wire logic [3:0] timer_oe,
  input wire logic [NPINS-1:0] port6_pin_o,
  input wire logic [NPINS-1:0] port6_pin_oe,
  input wire logic [NPINS-1:0] port8_pin_o,
  input wire logic [NPINS-1:0] port8_pin_oe,
  input wire logic [NPINS-1:0] porta_pin_o,
  input wire logic [NPINS-1:0] porta_pin_oe,
  input wire logic bus_request_input
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Held port 8 pins stay frozen
  property p_hold;
    (power_state == 3'h2 || power_state == 3'h4) [*3] |-> $stable(port8_pin_o) && $stable(port8_pin_oe);
  endproperty
  a_hold: assert property (p_hold) else $error("held pin moved");
  property p_req_stby;
    (power_state == 3'h2) [*3] |-> $stable(port6_pin_o[1]) && $stable(port6_pin_oe[1]);
  endproperty
  a_req_stby: assert property (p_req_stby) else $error("request pin moved");
  property p_gnt_stby;
    (power_state == 3'h2) [*3] |-> $stable(port6_pin_o[2]) && $stable(port6_pin_oe[2]);
  endproperty
  a_gnt_stby: assert property (p_gnt_stby) else $error("grant pin moved");
  property p_req_run;
    bus_request_input |-> !port6_pin_oe[1] && power_state <= 3'h1;
  endproperty
  a_req_run: assert property (p_req_run) else $error("request pin driven");
  property p_gnt_rel;
    (power_state == 3'h4) [*3] |-> port6_pin_oe[2] && !port6_pin_o[2];
  endproperty
  a_gnt_rel: assert property (p_gnt_rel) else $error("grant not low");
  property p_in_only;
    !port8_pin_oe[1];
  endproperty
  a_in_only: assert property (p_in_only) else $error("input pin driven");
  property p_timer;
    (power_state == 3'h4) [*3] ##0 (op_mode == 3'h3 || op_mode == 3'h4) |->
      (((porta_pin_o[7:4] ^ $past(timer_out)) | ~porta_pin_oe[7:4]) & $past(timer_oe)) == 4'h0;
  endproperty
  a_timer: assert property (p_timer) else $error("timer pin wrong");
endmodule
bind pin_state_by_power_mode pin_state_checker #(.NPINS(NPINS)) u_chk (.pclk, .presetn, .power_state,
  .op_mode, .timer_out, .timer_oe, .port6_pin_o, .port6_pin_oe, .port8_pin_o, .port8_pin_oe,
  .porta_pin_o, .porta_pin_oe, .bus_request_input);
`default_nettype wire

// *** sim/ext_pins.sv ***
// Model of the external pins and bus master
`timescale 1ns/1ps
`default_nettype none
module ext_pins (
  input wire logic pclk,
  input wire logic req,
  input wire logic take,
  input wire logic [23:0] drv_o,
  input wire logic [23:0] drv_oe,
  output logic [23:0] pin_i,
  output logic bus_released
);
  logic [23:0] ext_q = 24'h5A5A5A;
  // Undriven lines toggle, master drives request
  always @(posedge pclk) begin
    ext_q <= ~ext_q;
    bus_released <= take;
  end
  assign pin_i = (drv_oe & drv_o) | (~drv_oe & {ext_q[23:2], req, ext_q[0]});
endmodule
`default_nettype wire

// *** sim/pin_state_by_power_mode_bench.sv ***
// Self-checking bench for the pin state controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_fail++; $display("[FAIL] %0t got %0h exp %0h", $time, a, b); end end
module pin_state_by_power_mode_bench;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, sleep_req = 0, wake_req = 0;
  logic hw_standby_n = 1;
  logic req = 0, take = 0, slv, pready, pslverr, bus_request_input, bus_released;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rdat;
  logic [2:0] op_mode = 3'h3, power_state;
  logic [3:0] timer_out = 0, timer_oe = 0;
  logic [7:0] v;
  wire [23:0] pin_i, pin_o, pin_oe;
  logic [7:0] m [int];
  int seed = 13540, n_fail = 0, checked = 0, cyc = 0;
  pin_state_by_power_mode dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .op_mode, .hw_standby_n, .bus_released, .sleep_req, .wake_req, .timer_out, .timer_oe,
    .port6_pin_i(pin_i[7:0]), .port6_pin_o(pin_o[7:0]), .port6_pin_oe(pin_oe[7:0]),
    .port8_pin_i(pin_i[15:8]), .port8_pin_o(pin_o[15:8]), .port8_pin_oe(pin_oe[15:8]),
    .porta_pin_i(pin_i[23:16]), .porta_pin_o(pin_o[23:16]), .porta_pin_oe(pin_oe[23:16]),
    .bus_request_input, .power_state);
  ext_pins far (.pclk, .req, .take, .drv_o(pin_o), .drv_oe(pin_oe), .pin_i, .bus_released);
  initial forever #20 pclk = ~pclk;
  // Hang guard
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("checked %0d failed %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdat = prdata;
    slv = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    if (a == 12'h00C) d = d & 8'hFD;
    m[a] = d;
    apb(1, a, {24'h0, d});
  endtask
  task automatic rd(input logic [11:0] a);
    apb(0, a, 32'h0);
    `CHK(rdat, {24'h0, m[a]})
  endtask
  task automatic wst(input logic [2:0] s);
    int n;
    n = 0;
    while (power_state !== s && n < 40) begin
      @(posedge pclk);
      n++;
    end
    repeat (3) @(posedge pclk);
    #1;
    `CHK(power_state, s)
  endtask
  // Main sequence
  initial begin
    op_mode = 3'h3 + 3'($random(seed) & 1);
    repeat (3) @(posedge pclk);
    presetn <= 1;
    #1;
    `CHK(pin_oe, 24'h0)
    `CHK(power_state, 3'h0)
    for (int a = 4; a <= 28; a += 4) begin
      wr(12'(a), 8'($random(seed)));
      rd(12'(a));
    end
    apb(0, 12'h100, 32'h0);
    `CHK({slv, rdat}, 33'h100000000)
    $display("regs done");
    wr(12'h004, 8'hFF);
    wr(12'h00C, 8'hFF);
    wst(3'h0);
    `CHK(pin_o[7:0], m[12'h008])
    `CHK(pin_oe[15:8], m[12'h00C])
    wr(12'h000, 8'h01);
    @(posedge pclk) req <= 1;
    wst(3'h0);
    `CHK({bus_request_input, pin_oe[1]}, 2'b10)
    `CHK({pin_o[2], pin_oe[2]}, 2'b11)
    @(posedge pclk) req <= 0;
    wst(3'h0);
    `CHK(bus_request_input, 1'b0)
    $display("run done");
    for (int b = 0; b < 2; b++) begin
      wr(12'h000, {6'h0, 1'b1, 1'(b)});
      @(posedge pclk) sleep_req <= 1;
      @(posedge pclk) sleep_req <= 0;
      wst(3'h2);
      `CHK(pin_o[15:8] & m[12'h00C] | {pin_oe[15:8], 8'h0}, m[12'h010] & m[12'h00C] | {m[12'h00C], 8'h0})
      `CHK({pin_oe[1], pin_o[1] | 1'(b)}, {!b, m[12'h008][1] | 1'(b)})
      `CHK({pin_oe[2], pin_o[2]}, {1'b1, b ? 1'b1 : m[12'h008][2]})
      v = 8'($random(seed));
      wr(12'h014, 8'hFF);
      wr(12'h018, v);
      wst(3'h2);
      `CHK({pin_oe[23:20], pin_o[23:20]}, {4'hF, v[7:4]})
      @(posedge pclk) wake_req <= 1;
      wst(3'h0);
      @(posedge pclk) wake_req <= 0;
    end
    $display("standby done");
    wr(12'h000, 8'h01);
    wr(12'h01C, 8'hFF);
    @(posedge pclk);
    timer_oe <= 4'($random(seed));
    timer_out <= 4'($random(seed));
    take <= 1;
    wst(3'h4);
    `CHK((pin_o[23:20] ^ timer_out) & timer_oe, 4'h0)
    `CHK((pin_o[23:20] ^ v[7:4]) & ~timer_oe, 4'h0)
    `CHK(pin_oe[23:20], 4'hF)
    `CHK({pin_o[2], pin_oe[2], pin_oe[15:8]}, {2'b01, m[12'h00C]})
    @(posedge pclk) take <= 0;
    wst(3'h0);
    $display("release done");
    @(posedge pclk) hw_standby_n <= 0;
    wst(3'h3);
    `CHK(pin_oe, 24'h0)
    @(posedge pclk) hw_standby_n <= 1;
    wst(3'h0);
    $display("hw standby done");
    complete_run();
  end
endmodule
`default_nettype wire
